/* File: design/pwm_time_base_consts.svh */
// Constants of the PWM time base: register indices, field positions, resets.
// Assumes inclusion by bare name from the package; the core module uses its macros without including it.
`ifndef PWM_TIME_BASE_CONSTS_SVH
`define PWM_TIME_BASE_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define IDX_CONTROL 8'h00
`define IDX_STATUS 8'h02
`define IDX_FINE 8'h04
`define IDX_PHASE 8'h06
`define IDX_COUNTER 8'h08
`define IDX_PERIOD 8'h0A

// Control register field positions.
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 1
`define CTL_PHASE_EN 2
`define CTL_DIRECT_LOAD 3
`define CTL_SOFT_SYNC 6
`define CTL_HSDIV_LSB 7
`define CTL_HSDIV_MSB 9
`define CTL_CLKDIV_LSB 10
`define CTL_CLKDIV_MSB 12
`define CTL_PHASE_DIR 13

// Control register reset values.
`define RST_MODE 2'h3
`define RST_HSDIV 3'h1
`define RST_CLKDIV 3'h0

// Status register field positions.
`define STS_DIR 0
`define STS_SYNC 1
`define STS_MAX 2

// Fine phase field position.
`define FINE_LSB 8
`define FINE_MSB 15

`define COUNT_MAX_VALUE 16'hFFFF
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define DATA_ZERO 32'h0000_0000
`define PRESCALE_ONE 11'h001
`define PRESCALE_ZERO 11'h000
`define RST_FINE 8'h00

`endif

/* File: design/pwm_time_base_pkg.sv */
// Types shared by the PWM time base.
// Assumes the constants header is on the include path.
package pwm_time_base_pkg;
  `include "pwm_time_base_consts.svh"

  // Order follows the counter-mode encoding of the control register.
  typedef enum logic [1:0] {mode_up, mode_down, mode_up_down, mode_freeze} count_mode_e;

  typedef logic [15:0] count_t;
endpackage

/* File: design/pwm_time_base_core.sv */
// PWM time base core: 16-bit counter with phase load, shadowed period and status flags.
// Assumes a classic Wishbone master on clk and a sync_input synchronous to clk.
`timescale 1ns/100ps

module pwm_time_base_core #(
  parameter int ADDR_WIDTH = 8,
  parameter bit HAS_FINE_PHASE = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sync_input,
  output pwm_time_base_pkg::count_t counter_out,
  output logic count_up_out,
  output logic base_tick_out
);
  import pwm_time_base_pkg::*;

  localparam int IDX_WIDTH = ADDR_WIDTH - 2;

  // Four index bits above the byte offset are needed to reach the highest register.
  if (ADDR_WIDTH < 6) begin : g_addr_width_check
    $error("ADDR_WIDTH must be at least 6 to reach every register");
  end

  // Reset release through two flip-flops.
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Bus decode.
  logic [IDX_WIDTH-1:0] word_idx;
  logic req;
  logic wr;
  logic lane_lo;
  logic lane_hi;
  logic sel_control;
  logic sel_status;
  logic sel_fine;
  logic sel_phase;
  logic sel_counter;
  logic sel_period;

  assign word_idx = wb_adr_i[ADDR_WIDTH-1:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign lane_lo = wb_sel_i[0];
  assign lane_hi = wb_sel_i[1];
  assign sel_control = word_idx == IDX_WIDTH'(`IDX_CONTROL);
  assign sel_status = word_idx == IDX_WIDTH'(`IDX_STATUS);
  assign sel_fine = word_idx == IDX_WIDTH'(`IDX_FINE);
  assign sel_phase = (word_idx == IDX_WIDTH'(`IDX_PHASE)) && HAS_FINE_PHASE;
  assign sel_counter = word_idx == IDX_WIDTH'(`IDX_COUNTER);
  assign sel_period = word_idx == IDX_WIDTH'(`IDX_PERIOD);

  // Byte-lane merge of a 16-bit register with the write data.
  function automatic count_t merge16(input count_t old, input logic [31:0] data,
                                     input logic lo, input logic hi);
    count_t res;
    res = old;
    if (lo) begin
      res[7:0] = data[7:0];
    end
    if (hi) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Control register.
  logic [1:0] mode_bits_q;
  logic phase_en_q;
  logic direct_load_q;
  logic [2:0] hsdiv_q;
  logic [2:0] clkdiv_q;
  logic phase_dir_q;
  logic soft_sync_q;
  count_mode_e mode;

  assign mode = count_mode_e'(mode_bits_q);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_bits_q <= `RST_MODE;
      phase_en_q <= 1'b0;
      direct_load_q <= 1'b0;
      hsdiv_q <= `RST_HSDIV;
      clkdiv_q <= `RST_CLKDIV;
      phase_dir_q <= 1'b0;
    end else if (wr && sel_control) begin
      if (lane_lo) begin
        mode_bits_q <= wb_dat_i[`CTL_MODE_MSB:`CTL_MODE_LSB];
        phase_en_q <= wb_dat_i[`CTL_PHASE_EN];
        direct_load_q <= wb_dat_i[`CTL_DIRECT_LOAD];
        hsdiv_q[0] <= wb_dat_i[`CTL_HSDIV_LSB];
      end
      if (lane_hi) begin
        hsdiv_q[2:1] <= wb_dat_i[`CTL_HSDIV_MSB:`CTL_HSDIV_LSB+1];
        clkdiv_q <= wb_dat_i[`CTL_CLKDIV_MSB:`CTL_CLKDIV_LSB];
        phase_dir_q <= wb_dat_i[`CTL_PHASE_DIR];
      end
    end
  end

  // Software sync force is a one-cycle pulse, never stored as readable state.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      soft_sync_q <= 1'b0;
    end else begin
      soft_sync_q <= wr && sel_control && lane_lo && wb_dat_i[`CTL_SOFT_SYNC];
    end
  end

  // External sync: each rising edge of the input is one event.
  logic sync_in_q;
  logic ext_sync;
  logic sync_event;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync_in_q <= 1'b0;
    end else begin
      sync_in_q <= sync_input;
    end
  end

  assign ext_sync = sync_input && !sync_in_q;
  assign sync_event = ext_sync || soft_sync_q;

  // Divided base clock: divisor is the high-speed factor times the power-of-two factor.
  logic [3:0] hs_factor;
  logic [10:0] divisor;
  logic [10:0] prescale_q;
  logic tick;

  assign hs_factor = (hsdiv_q == 3'h0) ? 4'h1 : {hsdiv_q, 1'b0};
  assign divisor = 11'({7'h00, hs_factor} << clkdiv_q);
  assign tick = prescale_q >= (divisor - `PRESCALE_ONE);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prescale_q <= `PRESCALE_ZERO;
    end else if (tick) begin
      prescale_q <= `PRESCALE_ZERO;
    end else begin
      prescale_q <= prescale_q + `PRESCALE_ONE;
    end
  end

  // Phase registers.
  count_t phase_q;
  logic [7:0] fine_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= `COUNT_ZERO;
    end else if (wr && sel_phase) begin
      phase_q <= merge16(phase_q, wb_dat_i, lane_lo, lane_hi);
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fine_q <= `RST_FINE;
    end else if (wr && sel_fine && lane_hi) begin
      fine_q <= wb_dat_i[`FINE_MSB:`FINE_LSB];
    end
  end

  // Period: one address, the direct-load bit picks the copy.
  count_t period_shadow_q;
  count_t period_active_q;
  count_t counter_q;
  logic dir_up_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      period_shadow_q <= `COUNT_ZERO;
    end else if (wr && sel_period && !direct_load_q) begin
      period_shadow_q <= merge16(period_shadow_q, wb_dat_i, lane_lo, lane_hi);
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      period_active_q <= `COUNT_ZERO;
    end else if (wr && sel_period && direct_load_q) begin
      period_active_q <= merge16(period_active_q, wb_dat_i, lane_lo, lane_hi);
    end else if (!direct_load_q && counter_q == `COUNT_ZERO) begin
      period_active_q <= period_shadow_q;
    end
  end

  // Counter: bus write first, then phase load, then counting on the divided tick.
  count_t count_next;
  logic dir_next;

  always_comb begin
    count_next = counter_q;
    dir_next = dir_up_q;
    unique case (mode)
      mode_up: begin
        dir_next = 1'b1;
        count_next = (counter_q >= period_active_q) ? `COUNT_ZERO : counter_q + `COUNT_ONE;
      end
      mode_down: begin
        dir_next = 1'b0;
        if (counter_q == `COUNT_ZERO || counter_q > period_active_q) begin
          count_next = period_active_q;
        end else begin
          count_next = counter_q - `COUNT_ONE;
        end
      end
      mode_up_down: begin
        if (period_active_q == `COUNT_ZERO) begin
          count_next = `COUNT_ZERO;
        end else if (dir_up_q) begin
          if (counter_q >= period_active_q) begin
            dir_next = 1'b0;
            count_next = counter_q - `COUNT_ONE;
          end else begin
            count_next = counter_q + `COUNT_ONE;
          end
        end else begin
          if (counter_q == `COUNT_ZERO) begin
            dir_next = 1'b1;
            count_next = counter_q + `COUNT_ONE;
          end else begin
            count_next = counter_q - `COUNT_ONE;
          end
        end
      end
      mode_freeze: begin
        count_next = counter_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      counter_q <= `COUNT_ZERO;
    end else if (wr && sel_counter) begin
      counter_q <= merge16(counter_q, wb_dat_i, lane_lo, lane_hi);
    end else if (sync_event && phase_en_q) begin
      counter_q <= phase_q;
    end else if (tick) begin
      counter_q <= count_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dir_up_q <= 1'b0;
    end else if (sync_event && phase_en_q && mode == mode_up_down) begin
      dir_up_q <= phase_dir_q;
    end else if (tick) begin
      dir_up_q <= dir_next;
    end
  end

  // Status flags; a set in the same cycle as a clear wins.
  logic max_flag_q;
  logic sync_flag_q;
  logic clr_max;
  logic clr_sync;

  assign clr_max = wr && sel_status && lane_lo && wb_dat_i[`STS_MAX];
  assign clr_sync = wr && sel_status && lane_lo && wb_dat_i[`STS_SYNC];

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      max_flag_q <= 1'b0;
    end else if (counter_q == `COUNT_MAX_VALUE) begin
      max_flag_q <= 1'b1;
    end else if (clr_max) begin
      max_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync_flag_q <= 1'b0;
    end else if (ext_sync) begin
      sync_flag_q <= 1'b1;
    end else if (clr_sync) begin
      sync_flag_q <= 1'b0;
    end
  end

  // Read mux; unmapped and reserved locations read zero.
  logic [31:0] rd_data;

  always_comb begin
    rd_data = `DATA_ZERO;
    if (sel_control) begin
      rd_data[`CTL_MODE_MSB:`CTL_MODE_LSB] = mode_bits_q;
      rd_data[`CTL_PHASE_EN] = phase_en_q;
      rd_data[`CTL_DIRECT_LOAD] = direct_load_q;
      rd_data[`CTL_HSDIV_MSB:`CTL_HSDIV_LSB] = hsdiv_q;
      rd_data[`CTL_CLKDIV_MSB:`CTL_CLKDIV_LSB] = clkdiv_q;
      rd_data[`CTL_PHASE_DIR] = phase_dir_q;
    end else if (sel_status) begin
      rd_data[`STS_MAX] = max_flag_q;
      rd_data[`STS_SYNC] = sync_flag_q;
      rd_data[`STS_DIR] = dir_up_q;
    end else if (sel_fine) begin
      rd_data[`FINE_MSB:`FINE_LSB] = fine_q;
    end else if (sel_phase) begin
      rd_data[15:0] = phase_q;
    end else if (sel_counter) begin
      rd_data[15:0] = counter_q;
    end else if (sel_period) begin
      rd_data[15:0] = direct_load_q ? period_active_q : period_shadow_q;
    end
  end

  // Wishbone answer: ack one cycle after the request, dropped the next cycle.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DATA_ZERO;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Observation outputs, registered.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      counter_out <= `COUNT_ZERO;
      count_up_out <= 1'b0;
      base_tick_out <= 1'b0;
    end else begin
      counter_out <= counter_q;
      count_up_out <= dir_up_q;
      base_tick_out <= tick;
    end
  end
endmodule

/* File: verif/pwm_time_base_chk.sv */
// Concurrent checks on the ports of the PWM time base core.
// Assumes one clock domain and a classic Wishbone master that drops stb after ack.
`timescale 1ns/100ps
module pwm_time_base_chk #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sync_input,
  input wire pwm_time_base_pkg::count_t counter_out,
  input wire logic count_up_out,
  input wire logic base_tick_out
);
  import pwm_time_base_pkg::*;
  logic take;
  logic written_q;
  count_t wd_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Remembers whether software has written anything yet, and the last write data.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      written_q <= 1'b0;
      wd_q <= 16'h0000;
    end else if (take && wb_we_i) begin
      written_q <= 1'b1;
      wd_q <= wb_dat_i[15:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_ack_follows: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_soft_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h00 |=> !wb_dat_o[6])
    else $error("soft sync bit read as one");
  a_fine_low: assert property (take && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o[7:0] == 8'h00)
    else $error("fine phase low byte not zero");
  a_sts_rsvd: assert property (take && !wb_we_i && wb_adr_i == 8'h08 |=> wb_dat_o[15:3] == 13'h0000)
    else $error("status reserved bits not zero");
  a_cnt_write: assert property (take && wb_we_i && wb_adr_i == 8'h20 &&
    wb_sel_i[1:0] == 2'h3 |=> ##1 counter_out == wd_q)
    else $error("counter write not applied at once");
  a_max_latched: assert property ((counter_out == 16'hFFFF) ##1
    (take && !wb_we_i && wb_adr_i == 8'h08) |=> wb_dat_o[2])
    else $error("count max flag not latched");
  a_frozen_reset: assert property (!written_q |-> counter_out == 16'h0000 && !count_up_out)
    else $error("counter moved before any write");
endmodule

bind pwm_time_base_core pwm_time_base_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
  .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_input(sync_input),
  .counter_out(counter_out), .count_up_out(count_up_out), .base_tick_out(base_tick_out)
);

/* File: verif/sync_source.sv */
// Model of the time base that feeds the sync input.
// Assumes clk is shared with the core; a fire request starts one pulse of width+1 cycles.
`timescale 1ns/100ps
module sync_source (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fire,
  input wire logic [1:0] width,
  output logic sync_input
);
  logic [1:0] left_q;
  // A wide pulse is still one event at the receiving edge detector.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_q <= 2'h0;
      sync_input <= 1'b0;
    end else if (fire) begin
      left_q <= width;
      sync_input <= 1'b1;
    end else if (left_q != 2'h0) begin
      left_q <= left_q - 2'h1;
    end else begin
      sync_input <= 1'b0;
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the PWM time base core.
// Assumes the core answers every request with ack one cycle after it is taken.
`timescale 1ns/100ps
module tb_top;
  import pwm_time_base_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  count_t cnt_out;
  logic up_out;
  logic sync;
  logic fire = 1'b0;
  logic [1:0] width = 2'h0;
  logic [31:0] rd;
  logic [15:0] x;
  logic [15:0] p;
  logic [2:0] h;
  logic [2:0] c;
  logic tick_out;
  int n_ticks;
  int err_total = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  pwm_time_base_core i_pwm_time_base_core (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sync_input(sync), .counter_out(cnt_out), .count_up_out(up_out), .base_tick_out(tick_out)
  );
  sync_source i_sync_source (
    .clk(clk), .reset_n(reset_n), .fire(fire), .width(width), .sync_input(sync)
  );
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Status word as software should see it: count max, sync seen, direction.
  function automatic logic [31:0] exp_status(input logic max_f, input logic sync_f,
                                             input logic up);
    return {29'h0000_0000, max_f, sync_f, up};
  endfunction
  // Clocks per divided tick: the high-speed factor times the power-of-two factor.
  function automatic int tick_div(input logic [2:0] hs, input logic [2:0] cd);
    return ((hs == 3'h0) ? 1 : 2 * int'(hs)) << cd;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    check("ack delay", 32'(n), 32'h0000_0002);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000);
    check(name, rd, exp);
  endtask
  task automatic pulse_sync();
    @(posedge clk);
    fire <= 1'b1;
    width <= 2'($urandom_range(3, 0));
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
  initial begin
    void'($urandom(40));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd_chk("reset value", 8'(i * 8), (i == 0) ? 32'h0000_0083 : 32'h0000_0000);
    end
    bus(1'b1, 8'h10, 16'hFFFF);
    rd_chk("fine bits", 8'h10, 32'h0000_FF00);
    bus(1'b1, 8'h08, 16'hFFFF);
    rd_chk("status reserved", 8'h08, 32'h0000_0000);
    repeat (4) begin
      x = 16'($urandom);
      bus(1'b1, 8'h20, x);
      rd_chk("counter", 8'h20, {16'h0000, x});
    end
    bus(1'b1, 8'h20, 16'hFFFF);
    rd_chk("max set", 8'h08, exp_status(1'b1, 1'b0, 1'b0));
    bus(1'b1, 8'h08, 16'h0004);
    rd_chk("max set wins", 8'h08, 32'h0000_0004);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h20, 16'h0000);
    rd_chk("max kept", 8'h08, 32'h0000_0004);
    bus(1'b1, 8'h08, 16'h0004);
    rd_chk("max clear", 8'h08, exp_status(1'b0, 1'b0, 1'b0));
    x = 16'($urandom_range(65534, 0));
    p = 16'($urandom_range(65534, 0));
    bus(1'b1, 8'h18, p);
    bus(1'b1, 8'h20, x);
    pulse_sync();
    rd_chk("no phase load", 8'h20, {16'h0000, x});
    rd_chk("sync seen", 8'h08, exp_status(1'b0, 1'b1, 1'b0));
    bus(1'b1, 8'h08, 16'h0000);
    rd_chk("sync kept", 8'h08, 32'h0000_0002);
    bus(1'b1, 8'h08, 16'h0002);
    rd_chk("sync clear", 8'h08, 32'h0000_0000);
    bus(1'b1, 8'h00, 16'h0007);
    pulse_sync();
    rd_chk("phase load", 8'h20, {16'h0000, p});
    bus(1'b1, 8'h08, 16'h0002);
    bus(1'b1, 8'h20, x);
    bus(1'b1, 8'h00, 16'h0047);
    rd_chk("soft sync load", 8'h20, {16'h0000, p});
    rd_chk("soft sync bit", 8'h00, 32'h0000_0007);
    rd_chk("no sync flag", 8'h08, 32'h0000_0000);
    x = 16'($urandom);
    p = 16'($urandom);
    bus(1'b1, 8'h00, 16'h0003);
    bus(1'b1, 8'h20, 16'h0000);
    bus(1'b1, 8'h28, x);
    bus(1'b1, 8'h20, 16'h0005);
    bus(1'b1, 8'h28, p);
    rd_chk("period shadow", 8'h28, {16'h0000, p});
    bus(1'b1, 8'h00, 16'h000B);
    rd_chk("period active", 8'h28, {16'h0000, x});
    bus(1'b1, 8'h00, 16'h0003);
    bus(1'b1, 8'h20, 16'h0000);
    bus(1'b1, 8'h00, 16'h000B);
    rd_chk("period reload", 8'h28, {16'h0000, p});
    bus(1'b1, 8'h28, 16'h0004);
    bus(1'b1, 8'h00, 16'h0008);
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h08, 16'h0000);
    check("up dir", {31'h0, rd[0]}, 32'h0000_0001);
    check("up out", {31'h0, up_out}, 32'h0000_0001);
    bus(1'b0, 8'h20, 16'h0000);
    check("within period", {31'h0, rd[15:0] <= 16'h0004}, 32'h0000_0001);
    bus(1'b1, 8'h00, 16'h0009);
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h08, 16'h0000);
    check("down dir", {31'h0, rd[0]}, 32'h0000_0000);
    h = 3'($urandom_range(7, 0));
    c = 3'($urandom_range(2, 0));
    bus(1'b1, 8'h00, {3'h0, c, h, 7'h03});
    repeat (tick_div(h, c) + 2) @(posedge clk);
    n_ticks = 0;
    repeat (4 * tick_div(h, c)) begin
      @(posedge clk);
      if (tick_out === 1'b1) begin
        n_ticks++;
      end
    end
    check("tick rate", 32'(n_ticks), 32'h0000_0004);
    wrap_up();
  end
endmodule
